/* File: hw/add_with_carry_op_page_absolute_jump_and_cmpjump_exec.sv */
// Execute slice: add with carry, page jump, logical and, compare and branch
// Summary of operation
// - Add-with-carry immediate: two bytes, one state
// - Register/indirect forms need escape in native map
// - Carry, aux carry, overflow from bit carries
// - Direct port operand adds one state
// - AND direct,acc: two states, port adds two
// - Jump target: PC+2 top bits, opcode, byte
// - Page jump: low bits 00001, three states
// - Byte AND updates only negative and zero
// - Port destination reads output latch
// - Direct-destination AND: acc or immediate source
// - Accumulator-destination AND encodings decoded
// - Extended AND needs escape in compat map
// - Selector nibble chooses extended AND source
// - Carry AND clears on zero; complement form
// - Carry AND source only direct bit
// - Carry AND opcodes and extended bit prefix
// - Branch when unequal, PC-relative target
// - Carry set when destination below source
// - Only four compare operand pairings
`timescale 1ns/1ns
module add_with_carry_op_page_absolute_jump_and_cmpjump_exec
	import alu_slice_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic native_map_in,
	input wire logic issue_in,
	input wire logic esc_in,
	input wire logic bit_prefix_in,
	input wire logic [7:0] op_in,
	input wire logic [7:0] byte1_in,
	input wire logic [7:0] byte2_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] dest_in,
	input wire logic [7:0] src_in,
	input wire logic [7:0] port_latch_in,
	input wire logic src_bit_in,
	input wire logic carry_in,
	input wire logic aux_in,
	input wire logic excess_in,
	output logic busy_out,
	output logic done_out,
	output logic illegal_out,
	output logic [7:0] result_out,
	output logic result_we_out,
	output logic result_to_acc_out,
	output logic [15:0] next_pc_out,
	output logic pc_load_out,
	output logic carry_flag_out,
	output logic aux_carry_flag_out,
	output logic signed_excess_flag_out,
	output logic negative_flag_out,
	output logic zero_flag_out,
	output logic [3:0] states_out
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	op_class_t cls;
	src_mode_t src_mode;
	logic [2:0] nbytes;
	logic [3:0] base_states;
	logic port_twice, compl, legal;

	op_decoder u_dec (
		.native_map_in(native_map_in),
		.esc_in(esc_in),
		.bit_prefix_in(bit_prefix_in),
		.op_in(op_in),
		.sel_in(byte1_in[3:0]),
		.cls_out(cls),
		.src_out(src_mode),
		.bytes_out(nbytes),
		.states_out(base_states),
		.port_twice_out(port_twice),
		.compl_out(compl),
		.legal_out(legal)
	);

	function automatic logic is_port(input logic [7:0] addr);
		is_port = (addr == PORT0_ADDR) || (addr == PORT1_ADDR) ||
			(addr == PORT2_ADDR) || (addr == PORT3_ADDR);
	endfunction

	// Direct address is the first operand byte, except behind a selector byte
	logic port_hit;
	logic [3:0] total_states;
	always_comb
	begin
		port_hit = 1'b0;
		if (cls == CLS_CBIT && !bit_prefix_in)
			port_hit = byte1_in[7] && is_port({byte1_in[7:3], 3'b000});
		else if (cls == CLS_AND_EXT)
			port_hit = (src_mode == SRC_DIR) && is_port(byte2_in);
		else if (src_mode == SRC_DIR || cls == CLS_AND_DIR)
			port_hit = is_port(byte1_in);
		total_states = base_states;
		if (port_hit)
			total_states = base_states + (port_twice ? 4'd2 : 4'd1);
		// A taken branch costs three more states
		if (cls == CLS_CMPB && unequal)
			total_states = total_states + 4'd3;
	end

	// Immediates ride in the operand bytes, except the 16-bit one; src_in for that one and for fetched operands
	logic [7:0] opnd;
	logic [7:0] cmp_dest;
	always_comb
	begin
		opnd = src_in;
		if (src_mode == SRC_ACC)
			opnd = acc_in;
		else if (cls == CLS_AND_DIR || cls == CLS_AND_EXT)
		begin
			if (src_mode == SRC_IMM)
				opnd = byte2_in;
		end
		else if (src_mode == SRC_IMM || (cls == CLS_CMPB && src_mode != SRC_DIR))
			opnd = byte1_in;
		cmp_dest = (op_in[7:1] == OP_CMPB_A_IMM[7:1]) ? acc_in : dest_in;
	end

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	logic [4:0] low_sum;
	logic [3:0] mid_sum;
	logic [1:0] top_sum;
	logic [7:0] add_with_carry_op_res;
	logic c3, c6, c7;
	always_comb
	begin
		low_sum = {1'b0, acc_in[3:0]} + {1'b0, opnd[3:0]} + {4'd0, carry_in};
		c3 = low_sum[4];
		mid_sum = {1'b0, acc_in[6:4]} + {1'b0, opnd[6:4]} + {3'd0, c3};
		c6 = mid_sum[3];
		top_sum = {1'b0, acc_in[7]} + {1'b0, opnd[7]} + {1'b0, c6};
		c7 = top_sum[1];
		add_with_carry_op_res = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
	end

	// Original port value comes from the output latch, not the pins
	logic [7:0] and_dest;
	logic [7:0] and_res;
	always_comb
	begin
		and_dest = dest_in;
		if (cls == CLS_AND_DIR && is_port(byte1_in))
			and_dest = port_latch_in;
		and_res = (cls == CLS_AND_ACC) ? (acc_in & opnd) : (and_dest & opnd);
	end

	logic [15:0] pc_after;
	logic [15:0] page_target;
	logic [15:0] rel_target;
	logic unequal;
	logic cbit_val;
	always_comb
	begin
		pc_after = pc_in + {13'd0, nbytes};
		page_target = {pc_after[15:11], op_in[7:5], byte1_in};
		rel_target = pc_after + {{8{byte2_in[7]}}, byte2_in};
		unequal = (cmp_dest != opnd);
		cbit_val = compl ? ~src_bit_in : src_bit_in;
	end

	logic go;
	assign go = issue_in && !busy_out;

	// ----------------------------------------
	// State counting
	// ----------------------------------------
	logic tbusy, tdone;
	state_timer u_tmr (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.load_in(go && legal),
		.count_in(total_states),
		.busy_out(tbusy),
		.done_out(tdone)
	);

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			states_out <= STATE_RESET;
		end
		else
		begin
			busy_out <= (go && legal) || (tbusy && !tdone);
			done_out <= tdone;
			illegal_out <= go && !legal;
			if (go && legal)
				states_out <= total_states;
		end
	end

	// ----------------------------------------
	// Results and flags, latched at issue
	// ----------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			result_out <= 8'h00;
			result_we_out <= 1'b0;
			result_to_acc_out <= 1'b0;
		end
		else if (go && legal)
		begin
			result_we_out <= 1'b0;
			result_to_acc_out <= 1'b0;
			case (cls)
				CLS_ADD_WITH_CARRY_OP:
				begin
					result_out <= add_with_carry_op_res;
					result_we_out <= 1'b1;
					result_to_acc_out <= 1'b1;
				end
				CLS_AND_ACC, CLS_AND_DIR, CLS_AND_EXT:
				begin
					result_out <= and_res;
					result_we_out <= 1'b1;
					result_to_acc_out <= (cls == CLS_AND_ACC);
				end
				default: result_out <= result_out;
			endcase
		end
		else
			result_we_out <= 1'b0;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			next_pc_out <= PC_RESET;
			pc_load_out <= 1'b0;
		end
		else if (go && legal)
		begin
			pc_load_out <= 1'b1;
			next_pc_out <= pc_after;
			if (cls == CLS_PAGE_ABSOLUTE_JUMP)
				next_pc_out <= page_target;
			else if (cls == CLS_CMPB && unequal)
				next_pc_out <= rel_target;
		end
		else
			pc_load_out <= 1'b0;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			carry_flag_out <= 1'b0;
			aux_carry_flag_out <= 1'b0;
			signed_excess_flag_out <= 1'b0;
			negative_flag_out <= 1'b0;
			zero_flag_out <= 1'b0;
		end
		else if (go)
		begin
			carry_flag_out <= carry_in;
			aux_carry_flag_out <= aux_in;
			signed_excess_flag_out <= excess_in;
			if (legal)
			begin
				case (cls)
					CLS_ADD_WITH_CARRY_OP:
					begin
						carry_flag_out <= c7;
						aux_carry_flag_out <= c3;
						signed_excess_flag_out <= c6 ^ c7;
						negative_flag_out <= add_with_carry_op_res[7];
						zero_flag_out <= (add_with_carry_op_res == 8'h00);
					end
					CLS_AND_ACC, CLS_AND_DIR, CLS_AND_EXT:
					begin
						negative_flag_out <= and_res[7];
						zero_flag_out <= (and_res == 8'h00);
					end
					CLS_CBIT: carry_flag_out <= carry_in & cbit_val;
					CLS_CMPB:
					begin
						carry_flag_out <= (cmp_dest < opnd);
						negative_flag_out <= cmp_dest[7];
						zero_flag_out <= !unequal;
					end
					default: carry_flag_out <= carry_in;
				endcase
			end
		end
	end
endmodule // add_with_carry_op_page_absolute_jump_and_cmpjump_exec

/* File: pkg/alu_slice_pkg.sv */
// Shared constants for the add/jump/and/compare execute slice
package alu_slice_pkg;
	// ----------------------------------------
	// Opcodes and prefixes
	// ----------------------------------------
	localparam logic [7:0] ESC_PREFIX = 8'ha5;
	localparam logic [7:0] BIT_PREFIX = 8'ha9;
	localparam logic [7:0] OP_ADD_WITH_CARRY_OP_IMM = 8'h34;
	localparam logic [7:0] OP_ADD_WITH_CARRY_OP_DIR = 8'h35;
	localparam logic [6:0] OP_ADD_WITH_CARRY_OP_IND = 7'h1b;
	localparam logic [4:0] OP_ADD_WITH_CARRY_OP_REG = 5'h07;
	localparam logic [4:0] OP_PAGE_ABSOLUTE_JUMP_LOW = 5'h01;
	localparam logic [7:0] OP_AND_DIR_A = 8'h52;
	localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
	localparam logic [7:0] OP_AND_A_IMM = 8'h54;
	localparam logic [7:0] OP_AND_A_DIR = 8'h55;
	localparam logic [6:0] OP_AND_A_IND = 7'h2b;
	localparam logic [4:0] OP_AND_A_REG = 5'h0b;
	localparam logic [7:0] OP_AND_RM = 8'h5c;
	localparam logic [7:0] OP_AND_WR = 8'h5d;
	localparam logic [7:0] OP_AND_EXT = 8'h5e;
	localparam logic [7:0] OP_CBIT_AND = 8'h82;
	localparam logic [7:0] OP_CBIT_ANDN = 8'hb0;
	localparam logic [4:0] OP_XBIT_AND = 5'h10;
	localparam logic [4:0] OP_XBIT_ANDN = 5'h1e;
	localparam logic [7:0] OP_CMPB_A_IMM = 8'hb4;
	localparam logic [7:0] OP_CMPB_A_DIR = 8'hb5;
	localparam logic [6:0] OP_CMPB_IND = 7'h5b;
	localparam logic [4:0] OP_CMPB_REG = 5'h17;
	// ----------------------------------------
	// Selector nibble under the extended AND opcode
	// ----------------------------------------
	localparam logic [3:0] SEL_IMM8 = 4'h0;
	localparam logic [3:0] SEL_IMM16 = 4'h4;
	localparam logic [3:0] SEL_SHORT_DIRECT_ADDRESS_B = 4'h1;
	localparam logic [3:0] SEL_SHORT_DIRECT_ADDRESS_W = 4'h5;
	localparam logic [3:0] SEL_LONG_DIRECT_ADDRESS_B = 4'h3;
	localparam logic [3:0] SEL_LONG_DIRECT_ADDRESS_W = 4'h7;
	localparam logic [3:0] SEL_IND_W = 4'h9;
	localparam logic [3:0] SEL_IND_D = 4'hb;
	// ----------------------------------------
	// Port direct addresses and reset values
	// ----------------------------------------
	localparam logic [7:0] PORT0_ADDR = 8'h80;
	localparam logic [7:0] PORT1_ADDR = 8'h90;
	localparam logic [7:0] PORT2_ADDR = 8'ha0;
	localparam logic [7:0] PORT3_ADDR = 8'hb0;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [3:0] STATE_RESET = 4'h0;
	typedef enum logic [3:0] {
		CLS_NONE, CLS_ADD_WITH_CARRY_OP, CLS_PAGE_ABSOLUTE_JUMP, CLS_AND_DIR, CLS_AND_ACC, CLS_AND_EXT,
		CLS_CBIT, CLS_CMPB
	} op_class_t;
	typedef enum logic [2:0] {
		SRC_IMM, SRC_DIR, SRC_IND, SRC_REG, SRC_ACC, SRC_LONG_DIRECT_ADDRESS, SRC_PTR, SRC_IMM16
	} src_mode_t;
endpackage

/* File: hw/op_decoder.sv */
// Opcode decoder: class, source mode, length and state count
`timescale 1ns/1ns
module op_decoder
	import alu_slice_pkg::*;
(
	input wire logic native_map_in,
	input wire logic esc_in,
	input wire logic bit_prefix_in,
	input wire logic [7:0] op_in,
	input wire logic [3:0] sel_in,
	output op_class_t cls_out,
	output src_mode_t src_out,
	output logic [2:0] bytes_out,
	output logic [3:0] states_out,
	output logic port_twice_out,
	output logic compl_out,
	output logic legal_out
);
	// Escape is needed for short forms in native map and for long forms in compat map
	logic short_ok, long_ok;
	always_comb
	begin
		short_ok = (esc_in == native_map_in);
		long_ok = (esc_in != native_map_in);
		cls_out = CLS_NONE;
		src_out = SRC_IMM;
		bytes_out = 3'd1;
		states_out = 4'd1;
		port_twice_out = 1'b0;
		compl_out = 1'b0;
		legal_out = 1'b1;
		if (bit_prefix_in)
		begin
			if (op_in[7:3] == OP_XBIT_AND || op_in[7:3] == OP_XBIT_ANDN)
			begin
				cls_out = CLS_CBIT;
				src_out = SRC_DIR;
				compl_out = (op_in[7:3] == OP_XBIT_ANDN);
				bytes_out = native_map_in ? 3'd3 : 3'd4;
				states_out = native_map_in ? 4'd2 : 4'd3;
				legal_out = long_ok;
			end
			else
				legal_out = 1'b0;
		end
		else if (op_in == OP_ADD_WITH_CARRY_OP_IMM)
		begin
			cls_out = CLS_ADD_WITH_CARRY_OP;
			bytes_out = 3'd2;
		end
		else if (op_in == OP_ADD_WITH_CARRY_OP_DIR)
		begin
			cls_out = CLS_ADD_WITH_CARRY_OP;
			src_out = SRC_DIR;
			bytes_out = 3'd2;
		end
		else if (op_in[7:1] == OP_ADD_WITH_CARRY_OP_IND || op_in[7:3] == OP_ADD_WITH_CARRY_OP_REG)
		begin
			cls_out = CLS_ADD_WITH_CARRY_OP;
			src_out = (op_in[3]) ? SRC_REG : SRC_IND;
			bytes_out = esc_in ? 3'd2 : 3'd1;
			states_out = (op_in[3] ? 4'd1 : 4'd2) + {3'd0, esc_in};
			legal_out = short_ok;
		end
		else if (op_in[4:0] == OP_PAGE_ABSOLUTE_JUMP_LOW)
		begin
			cls_out = CLS_PAGE_ABSOLUTE_JUMP;
			bytes_out = 3'd2;
			states_out = 4'd3;
		end
		else if (op_in == OP_AND_DIR_A || op_in == OP_AND_DIR_IMM)
		begin
			cls_out = CLS_AND_DIR;
			src_out = op_in[0] ? SRC_IMM : SRC_ACC;
			bytes_out = op_in[0] ? 3'd3 : 3'd2;
			states_out = op_in[0] ? 4'd3 : 4'd2;
			port_twice_out = ~op_in[0];
		end
		else if (op_in == OP_AND_A_IMM || op_in == OP_AND_A_DIR)
		begin
			cls_out = CLS_AND_ACC;
			src_out = op_in[0] ? SRC_DIR : SRC_IMM;
			bytes_out = 3'd2;
		end
		// Register codes 4-6 are the extended forms in the other map, where code 7 is refused
		else if (op_in[7:1] == OP_AND_A_IND ||
			(op_in[7:3] == OP_AND_A_REG && !(op_in[2] && long_ok)))
		begin
			cls_out = CLS_AND_ACC;
			src_out = op_in[3] ? SRC_REG : SRC_IND;
			bytes_out = esc_in ? 3'd2 : 3'd1;
			states_out = (op_in[3] ? 4'd1 : 4'd2) + {3'd0, esc_in};
			legal_out = short_ok;
		end
		else if (op_in == OP_AND_RM || op_in == OP_AND_WR || op_in == OP_AND_EXT)
		begin
			cls_out = CLS_AND_EXT;
			src_out = SRC_REG;
			bytes_out = 3'd2;
			states_out = (op_in == OP_AND_WR) ? 4'd2 : 4'd1;
			legal_out = long_ok;
			if (op_in == OP_AND_EXT)
			begin
				case (sel_in)
					SEL_IMM8: begin src_out = SRC_IMM; bytes_out = 3'd3; states_out = 4'd2; end
					SEL_IMM16: begin src_out = SRC_IMM16; bytes_out = 3'd4; states_out = 4'd3; end
					SEL_SHORT_DIRECT_ADDRESS_B, SEL_SHORT_DIRECT_ADDRESS_W:
					begin
						src_out = SRC_DIR;
						bytes_out = 3'd3;
						states_out = sel_in[2] ? 4'd3 : 4'd2;
					end
					SEL_LONG_DIRECT_ADDRESS_B, SEL_LONG_DIRECT_ADDRESS_W:
					begin
						src_out = SRC_LONG_DIRECT_ADDRESS;
						bytes_out = 3'd4;
						states_out = sel_in[2] ? 4'd3 : 4'd2;
					end
					SEL_IND_W: begin src_out = SRC_PTR; bytes_out = 3'd3; states_out = 4'd2; end
					SEL_IND_D: begin src_out = SRC_PTR; bytes_out = 3'd3; states_out = 4'd3; end
					default: legal_out = 1'b0;
				endcase
			end
			if (esc_in)
			begin
				bytes_out = bytes_out + 3'd1;
				states_out = states_out + 4'd1;
			end
		end
		else if (op_in == OP_CBIT_AND || op_in == OP_CBIT_ANDN)
		begin
			cls_out = CLS_CBIT;
			src_out = SRC_DIR;
			compl_out = (op_in == OP_CBIT_ANDN);
			bytes_out = 3'd2;
		end
		else if (op_in == OP_CMPB_A_IMM || op_in == OP_CMPB_A_DIR)
		begin
			cls_out = CLS_CMPB;
			src_out = op_in[0] ? SRC_DIR : SRC_IMM;
			bytes_out = 3'd3;
			states_out = op_in[0] ? 4'd3 : 4'd2;
		end
		else if (op_in[7:1] == OP_CMPB_IND || op_in[7:3] == OP_CMPB_REG)
		begin
			cls_out = CLS_CMPB;
			src_out = op_in[3] ? SRC_REG : SRC_IND;
			bytes_out = esc_in ? 3'd4 : 3'd3;
			states_out = (op_in[3] ? 4'd2 : 4'd3) + {3'd0, esc_in};
			legal_out = short_ok;
		end
		else
			legal_out = 1'b0;
	end
endmodule // op_decoder

/* File: hw/state_timer.sv */
// Counts execution states of the current instruction
`timescale 1ns/1ns
module state_timer
	import alu_slice_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic load_in,
	input wire logic [3:0] count_in,
	output logic busy_out,
	output logic done_out
);
	logic [3:0] left_q;
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			left_q <= STATE_RESET;
		else if (load_in)
			left_q <= count_in;
		else if (left_q != STATE_RESET)
			left_q <= left_q - 4'd1;
	end
	assign busy_out = (left_q != STATE_RESET);
	assign done_out = (left_q == 4'd1);
endmodule // state_timer

/* File: tb/exec_slice_sva.sv */
// Port assertions for the execute slice
`timescale 1ns/1ns
module exec_slice_sva
	import alu_slice_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic native_map_in,
	input wire logic issue_in,
	input wire logic esc_in,
	input wire logic bit_prefix_in,
	input wire logic [7:0] op_in,
	input wire logic [7:0] byte1_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic src_bit_in,
	input wire logic carry_in,
	input wire logic busy_out,
	input wire logic done_out,
	input wire logic illegal_out,
	input wire logic result_we_out,
	input wire logic pc_load_out,
	input wire logic [15:0] next_pc_out,
	input wire logic carry_flag_out,
	input wire logic aux_carry_flag_out,
	input wire logic signed_excess_flag_out,
	input wire logic [3:0] states_out
);
	// ----------------------------------------
	// Expected values from the operands
	// ----------------------------------------
	wire logic take = issue_in && !busy_out;
	wire logic [8:0] sum_all = acc_in + byte1_in + carry_in;
	wire logic [4:0] sum_low = acc_in[3:0] + byte1_in[3:0] + carry_in;
	wire logic [7:0] sum_seven = acc_in[6:0] + byte1_in[6:0] + carry_in;
	wire logic [2:0] add_with_carry_op_flags = {sum_all[8], sum_low[4], sum_all[8] ^ sum_seven[7]};
	wire logic [2:0] seen_flags = {carry_flag_out, aux_carry_flag_out, signed_excess_flag_out};
	wire logic [15:0] pc_two = pc_in + 16'h0002;
	wire logic [15:0] page_target = {pc_two[15:11], op_in[7:5], byte1_in};
	wire logic port_hit = byte1_in inside {PORT0_ADDR, PORT1_ADDR, PORT2_ADDR, PORT3_ADDR};
	wire logic acc_below = acc_in < byte1_in;
	// Prefixed bit ops share the low opcode bits of the page jump
	wire logic jump_take = take && op_in[4:0] == OP_PAGE_ABSOLUTE_JUMP_LOW && !esc_in && !bit_prefix_in;
	default clocking dc @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	a_add_with_carry_op_one_state: assert property (
		take && op_in == OP_ADD_WITH_CARRY_OP_IMM |=> result_we_out && states_out == 4'h1 ##1 done_out && !busy_out)
		else $error("add immediate timing wrong");
	a_add_with_carry_op_flag_set: assert property (
		take && op_in == OP_ADD_WITH_CARRY_OP_IMM |=> seen_flags == $past(add_with_carry_op_flags))
		else $error("add flags wrong");
	a_escape_needed: assert property (
		take && native_map_in && !esc_in && op_in[7:3] == OP_ADD_WITH_CARRY_OP_REG |=> illegal_out && !busy_out)
		else $error("short form taken without escape");
	a_page_target: assert property (
		jump_take |=> pc_load_out && next_pc_out == $past(page_target))
		else $error("page jump target wrong");
	a_page_flags_kept: assert property (
		jump_take |=> states_out == 4'h3 && carry_flag_out == $past(carry_in) && !result_we_out)
		else $error("page jump timing or flags wrong");
	a_and_port_extra: assert property (
		take && op_in == OP_AND_DIR_A |=> states_out == ($past(port_hit) ? 4'h4 : 4'h2))
		else $error("direct and state count wrong");
	a_carry_and_clear: assert property (
		take && op_in == OP_CBIT_AND && !bit_prefix_in && !src_bit_in |=> !carry_flag_out)
		else $error("carry and did not clear");
	a_cmp_carry_below: assert property (
		take && op_in == OP_CMPB_A_IMM |=> carry_flag_out == $past(acc_below) && !result_we_out)
		else $error("compare carry wrong");
	c_cmp_taken: cover property (take && op_in == OP_CMPB_A_IMM && acc_below);
	c_and_port: cover property (take && op_in == OP_AND_DIR_A && port_hit);
	c_refused: cover property (illegal_out);
endmodule // exec_slice_sva

bind add_with_carry_op_page_absolute_jump_and_cmpjump_exec exec_slice_sva exec_slice_sva_i (.*);

/* File: tb/tb_add_with_carry_op_page_absolute_jump_and_cmpjump_exec.sv */
// Directed bench for the execute slice
`timescale 1ns/1ns
module tb_add_with_carry_op_page_absolute_jump_and_cmpjump_exec
	import alu_slice_pkg::*;
;
	logic core_clk_in, sys_rst_in, native_map_in, issue_in, esc_in, bit_prefix_in;
	logic src_bit_in, carry_in, aux_in, excess_in;
	logic [7:0] op_in, byte1_in, byte2_in, acc_in, dest_in, src_in, port_latch_in;
	logic [15:0] pc_in, next_pc_out;
	logic busy_out, done_out, illegal_out, result_we_out, result_to_acc_out, pc_load_out;
	logic carry_flag_out, aux_carry_flag_out, signed_excess_flag_out;
	logic negative_flag_out, zero_flag_out;
	logic [7:0] result_out;
	logic [3:0] states_out, seen_len;
	logic seen_we, seen_load, seen_ill, seen_done;
	int fail_count, tests_run;
	logic [3:0] sel_tab [8] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h3, 4'h7, 4'h9, 4'hb};
	logic [7:0] acc_ops [4] = '{OP_AND_A_IMM, OP_AND_A_DIR, 8'h56, 8'h5b};

	add_with_carry_op_page_absolute_jump_and_cmpjump_exec add_with_carry_op_page_absolute_jump_and_cmpjump_exec_i (.*);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [16:0] seen, input logic [16:0] want, input string what);
		tests_run++;
		if (seen !== want)
		begin
			fail_count++;
			$display("mismatch at %0t: %s is %h, expected %h", $time, what, seen, want);
		end
	endtask

	// Pulses are caught in the answer cycle; busy is then followed to done
	task automatic run_op(input logic nat, esc, input logic [7:0] op, b1);
		native_map_in = nat;
		esc_in = esc;
		op_in = op;
		byte1_in = b1;
		issue_in = 1'b1;
		@(posedge core_clk_in);
		#1 issue_in = 1'b0;
		seen_we = result_we_out;
		seen_load = pc_load_out;
		seen_ill = illegal_out;
		seen_len = 4'h0;
		while (busy_out === 1'b1 && seen_len < 4'hf)
		begin
			@(posedge core_clk_in);
			#1 seen_len++;
		end
		seen_done = done_out;
	endtask

	task automatic check_len(input logic [3:0] n);
		check(seen_len, n, "states");
		check({seen_done, states_out}, {1'b1, n}, "done");
	endtask

	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_add_with_carry_op;
		acc_in = 8'hc3;
		carry_in = 1'b1;
		run_op(1'b0, 1'b0, OP_ADD_WITH_CARRY_OP_IMM, 8'haa);
		check({seen_we, result_to_acc_out, result_out}, 10'h36e, "sum");
		check({seen_load, next_pc_out}, 17'h10202, "next pc");
		check_len(4'h1);
		check({carry_flag_out, aux_carry_flag_out, signed_excess_flag_out}, 3'b101, "flags");
		acc_in = 8'h4f;
		run_op(1'b0, 1'b0, OP_ADD_WITH_CARRY_OP_IMM, 8'h30);
		check({carry_flag_out, aux_carry_flag_out, signed_excess_flag_out}, 3'b011, "flags");
		check({negative_flag_out, zero_flag_out, result_out}, 10'h280, "sum");
		run_op(1'b1, 1'b0, {OP_ADD_WITH_CARRY_OP_REG, 3'h2}, 8'h00);
		check(seen_ill, 1'b1, "no escape");
		run_op(1'b1, 1'b1, {OP_ADD_WITH_CARRY_OP_REG, 3'h2}, 8'h00);
		check_len(4'h2);
		run_op(1'b0, 1'b0, {OP_ADD_WITH_CARRY_OP_IND, 1'b1}, 8'h00);
		check_len(4'h2);
		$display("add with carry test done");
	endtask

	task automatic t_page_absolute_jump;
		pc_in = 16'h47fe;
		{carry_in, aux_in, excess_in} = 3'b101;
		run_op(1'b0, 1'b0, {3'b101, OP_PAGE_ABSOLUTE_JUMP_LOW}, 8'h23);
		check({seen_load, next_pc_out}, 17'h14d23, "target");
		check_len(4'h3);
		check({carry_flag_out, aux_carry_flag_out, signed_excess_flag_out}, 3'b101, "flags");
		run_op(1'b1, 1'b0, {3'b010, OP_PAGE_ABSOLUTE_JUMP_LOW}, 8'hff);
		check({seen_load, next_pc_out}, 17'h14aff, "target");
		check_len(4'h3);
		$display("page jump test done");
	endtask

	task automatic t_and;
		{carry_in, aux_in, excess_in} = 3'b111;
		{acc_in, src_in, dest_in, port_latch_in} = 32'h73730cf3;
		run_op(1'b0, 1'b0, OP_AND_DIR_A, 8'h30);
		check({negative_flag_out, result_to_acc_out, zero_flag_out, result_out}, 11'h100, "and");
		check({carry_flag_out, aux_carry_flag_out, signed_excess_flag_out}, 3'b111, "flags");
		check_len(4'h2);
		// Pins read 0c here, so only the latch gives 73
		run_op(1'b0, 1'b0, OP_AND_DIR_A, PORT1_ADDR);
		check(result_out, 8'h73, "latch");
		check_len(4'h4);
		src_in = 8'h5a;
		byte2_in = 8'h5a;
		run_op(1'b0, 1'b0, OP_AND_DIR_IMM, PORT2_ADDR);
		check(result_out, 8'h52, "latch");
		check_len(4'h4);
		src_in = 8'h3c;
		for (int i = 0; i < 4; i++)
		begin
			run_op(1'b0, 1'b0, acc_ops[i], 8'h3c);
			check({result_to_acc_out, result_out}, 9'h130, "acc and");
			check_len(i == 2 ? 4'h2 : 4'h1);
		end
		run_op(1'b1, 1'b0, acc_ops[3], 8'h3c);
		check(seen_ill, 1'b1, "no escape");
		for (int i = 0; i < 8; i++)
		begin
			run_op(1'b1, 1'b0, OP_AND_EXT, {4'h2, sel_tab[i]});
			check_len({3'b001, i[0]});
		end
		run_op(1'b0, 1'b1, OP_AND_EXT, 8'h20);
		check_len(4'h3);
		$display("logical and test done");
	endtask

	task automatic t_cbit;
		carry_in = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			src_bit_in = i[0];
			run_op(1'b0, 1'b0, i[1] ? OP_CBIT_ANDN : OP_CBIT_AND, 8'h20);
			check({seen_we, carry_flag_out}, {1'b0, i[0] ^ i[1]}, "carry and");
			check_len(4'h1);
		end
		bit_prefix_in = 1'b1;
		src_bit_in = 1'b0;
		run_op(1'b1, 1'b0, {OP_XBIT_AND, 3'h3}, 8'h20);
		check(carry_flag_out, 1'b0, "carry and");
		check_len(4'h2);
		bit_prefix_in = 1'b0;
		$display("carry and test done");
	endtask

	task automatic t_cmp;
		pc_in = 16'h0100;
		byte2_in = 8'hfe;
		{acc_in, dest_in, src_in} = 24'h343434;
		run_op(1'b0, 1'b0, OP_CMPB_A_IMM, 8'h56);
		check({seen_load, next_pc_out}, 17'h10101, "branch");
		check({seen_we, carry_flag_out}, 2'b01, "below");
		check_len(4'h5);
		run_op(1'b0, 1'b0, OP_CMPB_A_IMM, 8'h34);
		check({seen_we, carry_flag_out}, 2'b00, "equal");
		check_len(4'h2);
		run_op(1'b0, 1'b0, OP_CMPB_A_DIR, PORT3_ADDR);
		check_len(4'h4);
		// Unsigned compare: 80 is above 56 although negative as signed
		dest_in = 8'h80;
		run_op(1'b1, 1'b1, {OP_CMPB_REG, 3'h7}, 8'h56);
		check({seen_we, carry_flag_out}, 2'b00, "above");
		check_len(4'h6);
		$display("compare branch test done");
	endtask

	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	initial
	begin
		{sys_rst_in, native_map_in, issue_in, esc_in, bit_prefix_in} = 5'h10;
		{src_bit_in, carry_in, aux_in, excess_in} = 4'h0;
		{op_in, byte1_in, byte2_in, acc_in, dest_in, src_in, port_latch_in} = '0;
		pc_in = 16'h0200;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(posedge core_clk_in);
		#1 sys_rst_in = 1'b0;
		t_add_with_carry_op();
		t_page_absolute_jump();
		t_and();
		t_cbit();
		t_cmp();
		complete_run();
	end

	// Traffic takes some 110 cycles; the 3000-cycle limit means a hang
	initial
	begin
		#30000;
		fail_count++;
		complete_run();
	end
endmodule // tb_add_with_carry_op_page_absolute_jump_and_cmpjump_exec
